// File: hdl/event_counter_pkg.sv
// Purpose: Shared offsets, reset values and carriers for the event and error counter block
// Assumes: Byte-wide register ports on the network side and on the host side
// Notes: Offsets are byte addresses of the controller register space
package event_counter_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [15:0] host_serial_extended_config_ofs = 16'h0152;
	localparam logic [15:0] network_event_mask_ofs = 16'h0200;
	localparam logic [15:0] application_event_mask_ofs = 16'h0204;
	localparam logic [15:0] network_event_request_ofs = 16'h0210;
	localparam logic [15:0] application_event_request_ofs = 16'h0220;
	localparam logic [15:0] port_receive_error_counters_ofs = 16'h0300;
	localparam logic [15:0] port_forwarded_error_counters_ofs = 16'h0308;
	localparam logic [15:0] error_counters_last_ofs = 16'h030B;

	// ****************************************
	// Registers outside this block whose accesses clear requests
	// ****************************************
	localparam logic [15:0] link_layer_status_ofs = 16'h0110;
	localparam logic [15:0] application_layer_status_ofs = 16'h0130;
	localparam logic [15:0] application_layer_control_ofs = 16'h0120;
	localparam logic [15:0] latch_times_first_ofs = 16'h09B0;
	localparam logic [15:0] latch_times_last_ofs = 16'h09CF;
	localparam logic [15:0] sync_pulse_zero_status_ofs = 16'h098E;
	localparam logic [15:0] sync_pulse_one_status_ofs = 16'h098F;
	localparam logic [15:0] channel_activation_ofs = 16'h0806;
	localparam logic [15:0] channel_stride = 16'h0008;
	localparam logic [15:0] channel_area_last_ofs = 16'h087F;
	localparam logic [15:0] eeprom_command_ofs = 16'h0502;
	localparam logic [15:0] watchdog_status_ofs = 16'h0440;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int net_latch_bit = 0;
	localparam int net_link_bit = 2;
	localparam int net_app_status_bit = 3;
	localparam int net_channel_lsb = 4;
	localparam int app_control_bit = 0;
	localparam int app_latch_bit = 1;
	localparam int app_sync_zero_bit = 2;
	localparam int app_sync_one_bit = 3;
	localparam int app_activation_bit = 4;
	localparam int app_eeprom_bit = 5;
	localparam int app_watchdog_bit = 6;
	localparam int app_channel_lsb = 8;
	localparam int cfg_sync_zero_map_bit = 3;
	localparam int cfg_sync_one_map_bit = 7;

	// ****************************************
	// Reset values and counter top value
	// ****************************************
	localparam logic [15:0] network_event_mask_rst = 16'h0000;
	localparam logic [31:0] application_event_mask_rst = 32'h0000_0000;
	localparam logic [7:0] counter_max = 8'hFF;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} access_port_t;

	typedef struct packed {
		logic [3:0] enabled;
		logic [3:0] invalid_frame;
		logic [3:0] receive_error;
		logic [3:0] forwarded_error;
	} port_errors_t;

endpackage : event_counter_pkg

// File: hdl/saturating_counter.sv
// Purpose: Eight-bit event counter that stops at its top value
// Assumes: Count and clear strobes come from logic on the same clock
// Notes: Clear takes priority over a count in the same cycle
`timescale 1ns/100ps
module saturating_counter #(
	parameter int width = 8
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic count_i,
	input wire logic clear_i,
	output logic [width-1:0] value_o
);
	import event_counter_pkg::*;

	typedef struct packed {
		logic [width-1:0] value;
	} counter_state_t;

	counter_state_t state;
	counter_state_t next_state;

	always_comb begin
		next_state = state;
		if (clear_i) begin
			next_state.value = '0;
		end else if (count_i && state.value != {width{1'b1}}) begin
			next_state.value = state.value + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign value_o = state.value;
endmodule : saturating_counter

// File: hdl/slave_event_requests_and_error_counters.sv
// Purpose: Event requests, event masks and port error counters of a fieldbus slave
// Assumes: All event and error inputs are single-clock pulses or levels from local logic
// Notes: Both register ports are byte wide; read data appears one cycle after rd
//
// Notes on behaviour
// - Network mask bit one passes its request bit into the frame event field.
// - Application mask, host-writable only, gates request bits onto host interrupt.
// - Network bit 0 sets on network-owned latch change, clears on network latch-time read.
// - Network bit 2 sets on link status change, clears on status read.
// - Network bit 3 sets on application status change, clears on status read.
// - Network bits 4 upward mirror sync channels 0-7; bits 15:12 reserved.
// - Application bit 0 sets on network control register write outside emulation, clears on host read.
// - Application bit 1 sets on host-owned latch change, clears on host read.
// - If configured, application bit 2 follows sync pulse zero until status read.
// - If configured, application bit 3 follows sync pulse one until status read.
// - Application bit 4 sets on channel activation change, clears on host read.
// - Application bit 5 shows pending EEPROM command until host acknowledges it.
// - Application bit 6 sets on watchdog expiry, clears on watchdog status read.
// - Application bits 8-23 flag channel manager interrupts; bits 31:24 reserved.
// - Error counters of a port count only while that port is enabled.
// - Per port, low byte counts invalid frames, saturating at FF.
// - Per port, high byte counts receive error assertions, saturating.
// - Per port, eight-bit counter of forwarded errored frames, saturating at FF.
// - Network write anywhere in the counter range clears every counter.
`timescale 1ns/100ps
module slave_event_requests_and_error_counters #(
	parameter int ports = 4
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input event_counter_pkg::access_port_t network_side_i,
	input event_counter_pkg::access_port_t host_process_port_i,
	input wire logic [7:0] sync_latch_config_i,
	input wire logic device_emulation_i,
	input wire logic latch_change_i,
	input wire logic latch_host_owned_i,
	input wire logic link_layer_status_change_i,
	input wire logic application_layer_status_change_i,
	input wire logic [7:0] sync_channel_pending_i,
	input wire logic sync_pulse_zero_i,
	input wire logic sync_pulse_one_i,
	input wire logic activation_change_i,
	input wire logic eeprom_command_i,
	input wire logic watchdog_expired_i,
	input wire logic [15:0] sync_channel_manager_irq_i,
	input event_counter_pkg::port_errors_t port_errors_i,
	output logic [7:0] network_side_rdata_o,
	output logic [7:0] host_process_port_rdata_o,
	output logic [15:0] network_event_field_o,
	output logic host_interrupt_output_o
);
	import event_counter_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [15:0] net_mask;
		logic [31:0] app_mask;
		logic net_latch;
		logic net_link;
		logic net_app_status;
		logic app_control;
		logic app_latch;
		logic app_sync_zero;
		logic app_sync_one;
		logic app_activation;
		logic app_eeprom;
		logic app_watchdog;
		logic [7:0] net_rdata;
		logic [7:0] host_rdata;
		logic [15:0] event_field;
		logic irq;
	} block_state_t;

	block_state_t state;
	block_state_t next_state;

	logic [7:0] invalid_count [ports];
	logic [7:0] receive_count [ports];
	logic [7:0] forwarded_count [ports];
	logic counters_clear;
	logic [15:0] net_request;
	logic [31:0] app_request;

	// ****************************************
	// Address helpers
	// ****************************************
	function automatic logic hit(input logic [15:0] addr, input logic [15:0] base,
		input int bytes);
		logic [15:0] top;
		top = base + 16'(bytes - 1);
		return addr >= base && addr <= top;
	endfunction : hit

	function automatic logic in_range(input logic [15:0] addr, input logic [15:0] lo,
		input logic [15:0] hi);
		return addr >= lo && addr <= hi;
	endfunction : in_range

	// Any channel's activation byte, one per stride in the channel area
	function automatic logic activation_hit(input logic [15:0] addr);
		logic [15:0] rel;
		rel = addr - channel_activation_ofs;
		return addr >= channel_activation_ofs && addr <= channel_area_last_ofs
			&& rel[2:0] == channel_stride[2:0];
	endfunction : activation_hit

	function automatic logic [7:0] word_byte(input logic [31:0] word, input logic [1:0] lane);
		return word[8*lane +: 8];
	endfunction : word_byte

	// ****************************************
	// Request words as seen by software
	// ****************************************
	always_comb begin
		net_request = '0;
		net_request[net_latch_bit] = state.net_latch;
		net_request[net_link_bit] = state.net_link;
		net_request[net_app_status_bit] = state.net_app_status;
		net_request[net_channel_lsb +: 8] = sync_channel_pending_i;
		app_request = '0;
		app_request[app_control_bit] = state.app_control;
		app_request[app_latch_bit] = state.app_latch;
		app_request[app_sync_zero_bit] = state.app_sync_zero;
		app_request[app_sync_one_bit] = state.app_sync_one;
		app_request[app_activation_bit] = state.app_activation;
		app_request[app_eeprom_bit] = state.app_eeprom;
		app_request[app_watchdog_bit] = state.app_watchdog;
		app_request[app_channel_lsb +: 16] = sync_channel_manager_irq_i;
	end

	// ****************************************
	// Error counters
	// ****************************************
	// Any network write in the range clears all; the data byte is not looked at
	assign counters_clear = network_side_i.wr
		&& in_range(network_side_i.addr, port_receive_error_counters_ofs,
			error_counters_last_ofs);

	for (genvar p = 0; p < ports; p++) begin : g_port
		saturating_counter #(.width(8)) u_invalid (
			.clk_sys_i(clk_sys_i),
			.reset_i(reset_i),
			.count_i(port_errors_i.enabled[p] && port_errors_i.invalid_frame[p]),
			.clear_i(counters_clear),
			.value_o(invalid_count[p])
		);
		saturating_counter #(.width(8)) u_receive (
			.clk_sys_i(clk_sys_i),
			.reset_i(reset_i),
			.count_i(port_errors_i.enabled[p] && port_errors_i.receive_error[p]),
			.clear_i(counters_clear),
			.value_o(receive_count[p])
		);
		saturating_counter #(.width(8)) u_forwarded (
			.clk_sys_i(clk_sys_i),
			.reset_i(reset_i),
			.count_i(port_errors_i.enabled[p] && port_errors_i.forwarded_error[p]),
			.clear_i(counters_clear),
			.value_o(forwarded_count[p])
		);
	end

	// ****************************************
	// Register read mux, shared by both ports
	// ****************************************
	function automatic logic [7:0] read_byte(input logic [15:0] addr,
		input logic [15:0] net_mask, input logic [31:0] app_mask,
		input logic [15:0] net_req, input logic [31:0] app_req);
		logic [7:0] data;
		logic [15:0] rel;
		data = 8'h00;
		rel = '0;
		if (hit(addr, host_serial_extended_config_ofs, 2)) begin
			data = 8'h00;
		end else if (hit(addr, network_event_mask_ofs, 2)) begin
			data = word_byte({16'h0000, net_mask}, addr[1:0]);
		end else if (hit(addr, application_event_mask_ofs, 4)) begin
			data = word_byte(app_mask, addr[1:0]);
		end else if (hit(addr, network_event_request_ofs, 2)) begin
			data = word_byte({16'h0000, net_req}, addr[1:0]);
		end else if (hit(addr, application_event_request_ofs, 4)) begin
			data = word_byte(app_req, addr[1:0]);
		end else if (in_range(addr, port_receive_error_counters_ofs,
			error_counters_last_ofs)) begin
			rel = addr - port_receive_error_counters_ofs;
			if (addr < port_forwarded_error_counters_ofs) begin
				data = rel[0] ? receive_count[rel[2:1]] : invalid_count[rel[2:1]];
			end else begin
				data = forwarded_count[rel[1:0]];
			end
		end
		return data;
	endfunction : read_byte

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic net_rd;
		logic host_rd;
		logic host_wr;
		logic net_wr;
		net_rd = network_side_i.rd;
		host_rd = host_process_port_i.rd;
		host_wr = host_process_port_i.wr;
		net_wr = network_side_i.wr;
		next_state = state;

		// Mask writes: network mask from the network side only
		if (net_wr && hit(network_side_i.addr, network_event_mask_ofs, 2)) begin
			next_state.net_mask[8*network_side_i.addr[0] +: 8] = network_side_i.wdata;
		end
		if (host_wr && hit(host_process_port_i.addr, application_event_mask_ofs, 4)) begin
			next_state.app_mask[8*host_process_port_i.addr[1:0] +: 8] =
				host_process_port_i.wdata;
		end

		// Clears first, sets after, so an event in the clearing cycle survives
		if (net_rd && in_range(network_side_i.addr, latch_times_first_ofs,
			latch_times_last_ofs) && !latch_host_owned_i) begin
			next_state.net_latch = 1'b0;
		end
		if (latch_change_i && !latch_host_owned_i) begin
			next_state.net_latch = 1'b1;
		end
		if (net_rd && hit(network_side_i.addr, link_layer_status_ofs, 2)) begin
			next_state.net_link = 1'b0;
		end
		if (link_layer_status_change_i) begin
			next_state.net_link = 1'b1;
		end
		if (net_rd && hit(network_side_i.addr, application_layer_status_ofs, 2)) begin
			next_state.net_app_status = 1'b0;
		end
		if (application_layer_status_change_i) begin
			next_state.net_app_status = 1'b1;
		end

		if (host_rd && hit(host_process_port_i.addr, application_layer_control_ofs, 2)) begin
			next_state.app_control = 1'b0;
		end
		// Emulation mode copies control into status, so no event is raised then
		if (net_wr && hit(network_side_i.addr, application_layer_control_ofs, 2)
			&& !device_emulation_i) begin
			next_state.app_control = 1'b1;
		end
		if (host_rd && in_range(host_process_port_i.addr, latch_times_first_ofs,
			latch_times_last_ofs) && latch_host_owned_i) begin
			next_state.app_latch = 1'b0;
		end
		if (latch_change_i && latch_host_owned_i) begin
			next_state.app_latch = 1'b1;
		end
		// Sticky until the status read, hence only useful in acknowledge mode
		if (host_rd && host_process_port_i.addr == sync_pulse_zero_status_ofs) begin
			next_state.app_sync_zero = 1'b0;
		end
		if (sync_pulse_zero_i && sync_latch_config_i[cfg_sync_zero_map_bit]) begin
			next_state.app_sync_zero = 1'b1;
		end
		if (host_rd && host_process_port_i.addr == sync_pulse_one_status_ofs) begin
			next_state.app_sync_one = 1'b0;
		end
		if (sync_pulse_one_i && sync_latch_config_i[cfg_sync_one_map_bit]) begin
			next_state.app_sync_one = 1'b1;
		end
		if (host_rd && activation_hit(host_process_port_i.addr)) begin
			next_state.app_activation = 1'b0;
		end
		if (activation_change_i) begin
			next_state.app_activation = 1'b1;
		end
		if (host_wr && hit(host_process_port_i.addr, eeprom_command_ofs, 2)) begin
			next_state.app_eeprom = 1'b0;
		end
		if (eeprom_command_i) begin
			next_state.app_eeprom = 1'b1;
		end
		if (host_rd && hit(host_process_port_i.addr, watchdog_status_ofs, 2)) begin
			next_state.app_watchdog = 1'b0;
		end
		if (watchdog_expired_i) begin
			next_state.app_watchdog = 1'b1;
		end

		// Read data, captured from the words before this cycle's clears
		next_state.net_rdata = net_rd ? read_byte(network_side_i.addr, state.net_mask,
			state.app_mask, net_request, app_request) : state.net_rdata;
		next_state.host_rdata = host_rd ? read_byte(host_process_port_i.addr,
			state.net_mask, state.app_mask, net_request, app_request) : state.host_rdata;

		next_state.event_field = net_request & state.net_mask;
		next_state.irq = |(app_request & state.app_mask);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= '0;
			state.net_mask <= network_event_mask_rst;
			state.app_mask <= application_event_mask_rst;
		end else begin
			state <= next_state;
		end
	end

	assign network_side_rdata_o = state.net_rdata;
	assign host_process_port_rdata_o = state.host_rdata;
	assign network_event_field_o = state.event_field;
	assign host_interrupt_output_o = state.irq;
endmodule : slave_event_requests_and_error_counters

// File: dv/register_bus_agent.sv
// Purpose: Byte register master standing in for the network master or the host
// Assumes: One-cycle rd/wr strobes; read data is taken one cycle after the strobe edge
// Notes: Between accesses the address is inverted and wdata is inverted after a write or 5A after a read, so stale values never match
`timescale 1ns/100ps
module register_bus_agent (
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	output event_counter_pkg::access_port_t port_o
);
	import event_counter_pkg::*;
	initial port_o = '0;
	task automatic write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		port_o <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk_sys_i);
		port_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask : write
	task automatic read(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		port_o <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clk_sys_i);
		port_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'h5A};
		@(posedge clk_sys_i);
		d = rdata_i;
	endtask : read
endmodule : register_bus_agent

// File: dv/event_rules_asserts.sv
// Purpose: Port-level checks of event requests, masks and error counters
// Assumes: Byte accesses spaced as the bus agent makes them
// Notes: Mask tracking flags only see writes, not the mask values
`timescale 1ns/100ps
module event_rules_asserts #(
	parameter int ports = 4
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input event_counter_pkg::access_port_t network_side_i,
	input event_counter_pkg::access_port_t host_process_port_i,
	input wire logic link_layer_status_change_i,
	input wire logic [7:0] sync_channel_pending_i,
	input event_counter_pkg::port_errors_t port_errors_i,
	input wire logic [7:0] network_side_rdata_o,
	input wire logic [7:0] host_process_port_rdata_o,
	input wire logic [15:0] network_event_field_o,
	input wire logic host_interrupt_output_o
);
	import event_counter_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	logic net_mask_seen;
	logic app_mask_seen;
	logic quiet;
	logic net_clr;
	logic chg;
	assign quiet = ~|{port_errors_i.invalid_frame, port_errors_i.receive_error,
		port_errors_i.forwarded_error};
	assign net_clr = network_side_i.wr && (network_side_i.addr inside {[16'h0300:16'h030B]});
	assign chg = link_layer_status_change_i;
	// Until a mask is written it still holds its zero reset value
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			net_mask_seen <= 1'b0;
			app_mask_seen <= 1'b0;
		end else begin
			if (network_side_i.wr && network_side_i.addr[15:1] == 15'h0100)
				net_mask_seen <= 1'b1;
			if (host_process_port_i.wr && host_process_port_i.addr[15:2] == 14'h0081)
				app_mask_seen <= 1'b1;
		end
	end
	a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> network_event_field_o == 16'h0000
		&& !host_interrupt_output_o && network_side_rdata_o == 8'h00)
		else $error("outputs not cleared by reset");
	a_field_reserved: assert property (network_event_field_o[15:12] == 4'h0)
		else $error("reserved event field bits set");
	a_mirror_idle: assert property (sync_channel_pending_i == 8'h00 &&
		$past(sync_channel_pending_i) == 8'h00 |=> network_event_field_o[11:4] == 8'h00)
		else $error("channel bits set without pending channels");
	a_field_unmasked: assert property (!net_mask_seen |-> network_event_field_o == 16'h0000)
		else $error("event field set with zero mask");
	a_irq_unmasked: assert property (!app_mask_seen |-> !host_interrupt_output_o)
		else $error("interrupt with zero host mask");
	a_rdata_hold: assert property ((!network_side_i.rd |=> $stable(network_side_rdata_o))
		and (!host_process_port_i.rd |=> $stable(host_process_port_rdata_o)))
		else $error("read data changed without a read");
	a_ext_config_zero: assert property (host_process_port_i.rd &&
		host_process_port_i.addr[15:1] == 15'h00A9 |=> host_process_port_rdata_o == 8'h00)
		else $error("extended config not zero");
	a_link_clear: assert property ((network_side_i.rd && network_side_i.addr == 16'h0110
		&& !chg) ##1 (!chg) [*2] ##1 (network_side_i.rd && network_side_i.addr == 16'h0210)
		|=> !network_side_rdata_o[2])
		else $error("link status event not cleared by read");
	a_counter_clear: assert property (net_clr ##1 quiet ##1 (network_side_i.rd &&
		(network_side_i.addr inside {[16'h0300:16'h030B]})) |=> network_side_rdata_o == 8'h00)
		else $error("error counter not cleared by write");
endmodule : event_rules_asserts
bind slave_event_requests_and_error_counters event_rules_asserts #(.ports(ports)) u_asserts (
	.clk_sys_i(clk_sys_i), .reset_i(reset_i), .network_side_i(network_side_i),
	.host_process_port_i(host_process_port_i),
	.link_layer_status_change_i(link_layer_status_change_i),
	.sync_channel_pending_i(sync_channel_pending_i), .port_errors_i(port_errors_i),
	.network_side_rdata_o(network_side_rdata_o),
	.host_process_port_rdata_o(host_process_port_rdata_o),
	.network_event_field_o(network_event_field_o),
	.host_interrupt_output_o(host_interrupt_output_o)
);

// File: dv/testbench.sv
// Purpose: Self-checking bench for event requests, masks and error counters
// Assumes: Two bus agents, one per register port; event inputs driven on rising edges
// Notes: Row table covers set and clear of each sticky request
`timescale 1ns/100ps
module testbench;
	import event_counter_pkg::*;
	typedef struct packed {
		logic [3:0] ev;
		logic host;
		logic clr_wr;
		logic [15:0] clr;
		logic [7:0] exp;
	} row_t;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	access_port_t net_bus;
	access_port_t host_bus;
	logic [7:0] cfg = 8'h88;
	logic emul = 1'b0;
	logic owned = 1'b0;
	logic [7:0] pulse = 8'h00;
	logic [7:0] pending = 8'h00;
	logic [15:0] chan_irq = 16'h0000;
	port_errors_t errs = '0;
	logic [7:0] net_rdata;
	logic [7:0] host_rdata;
	logic [15:0] field;
	logic irq;
	logic [7:0] got;
	logic [15:0] req;
	int fail_count = 0;
	int checks_done = 0;
	row_t rows [10];
	always #5 clk_sys_i = ~clk_sys_i;
	register_bus_agent u_net (.clk_sys_i(clk_sys_i), .rdata_i(net_rdata), .port_o(net_bus));
	register_bus_agent u_host (.clk_sys_i(clk_sys_i), .rdata_i(host_rdata), .port_o(host_bus));
	slave_event_requests_and_error_counters #(.ports(4)) u_slave_event_requests_and_error_counters (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .network_side_i(net_bus),
		.host_process_port_i(host_bus), .sync_latch_config_i(cfg), .device_emulation_i(emul),
		.latch_change_i(pulse[0]), .latch_host_owned_i(owned),
		.link_layer_status_change_i(pulse[1]), .application_layer_status_change_i(pulse[2]),
		.sync_channel_pending_i(pending), .sync_pulse_zero_i(pulse[3]),
		.sync_pulse_one_i(pulse[4]), .activation_change_i(pulse[5]),
		.eeprom_command_i(pulse[6]), .watchdog_expired_i(pulse[7]),
		.sync_channel_manager_irq_i(chan_irq), .port_errors_i(errs),
		.network_side_rdata_o(net_rdata), .host_process_port_rdata_o(host_rdata),
		.network_event_field_o(field), .host_interrupt_output_o(irq)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic expect_rd(input logic host, input logic [15:0] a, input logic [7:0] want);
		if (host) u_host.read(a, got);
		else u_net.read(a, got);
		check($sformatf("byte at %h", a), got, want);
	endtask : expect_rd
	// Event 8 is a network write to the control register, others pulse one input
	task automatic fire(input logic [3:0] ev);
		if (ev == 4'h8) u_net.write(application_layer_control_ofs, 8'h02);
		else begin
			@(posedge clk_sys_i);
			pulse <= 8'h01 << ev;
			@(posedge clk_sys_i);
			pulse <= 8'h00;
		end
	endtask : fire
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		fail_count++;
		wrap_up();
	end
	initial begin
		rows[0] = '{4'h0, 1'b0, 1'b0, 16'h09B0, 8'h01};
		rows[1] = '{4'h1, 1'b0, 1'b0, 16'h0110, 8'h04};
		rows[2] = '{4'h2, 1'b0, 1'b0, 16'h0131, 8'h08};
		rows[3] = '{4'h8, 1'b1, 1'b0, 16'h0120, 8'h01};
		rows[4] = '{4'h0, 1'b1, 1'b0, 16'h09CF, 8'h02};
		rows[5] = '{4'h3, 1'b1, 1'b0, 16'h098E, 8'h04};
		rows[6] = '{4'h4, 1'b1, 1'b0, 16'h098F, 8'h08};
		rows[7] = '{4'h5, 1'b1, 1'b0, 16'h0816, 8'h10};
		rows[8] = '{4'h6, 1'b1, 1'b1, 16'h0502, 8'h20};
		rows[9] = '{4'h7, 1'b1, 1'b0, 16'h0440, 8'h40};
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		check("field after reset", field, 16'h0000);
		expect_rd(1'b0, network_event_mask_ofs, 8'h00);
		expect_rd(1'b1, application_event_mask_ofs, 8'h00);
		expect_rd(1'b1, host_serial_extended_config_ofs, 8'h00);
		expect_rd(1'b1, 16'h0153, 8'h00);
		expect_rd(1'b0, 16'h0FFF, 8'h00);
		foreach (rows[i]) begin
			owned <= rows[i].host;
			fire(rows[i].ev);
			req = rows[i].host ? application_event_request_ofs : network_event_request_ofs;
			expect_rd(rows[i].host, req, rows[i].exp);
			if (rows[i].clr_wr) u_host.write(rows[i].clr, 8'h00);
			else if (rows[i].host) u_host.read(rows[i].clr, got);
			else u_net.read(rows[i].clr, got);
			expect_rd(rows[i].host, req, 8'h00);
		end
		cfg <= 8'h00;
		fire(4'h3);
		expect_rd(1'b1, application_event_request_ofs, 8'h00);
		emul <= 1'b1;
		fire(4'h8);
		expect_rd(1'b1, application_event_request_ofs, 8'h00);
		emul <= 1'b0;
		// Network side may not open the host mask
		u_net.write(application_event_mask_ofs, 8'hFF);
		fire(4'h7);
		repeat (3) @(posedge clk_sys_i);
		check("irq", irq, 1'b0);
		u_host.write(application_event_mask_ofs, 8'h40);
		repeat (3) @(posedge clk_sys_i);
		check("irq", irq, 1'b1);
		u_host.write(application_event_mask_ofs, 8'h00);
		repeat (3) @(posedge clk_sys_i);
		check("irq", irq, 1'b0);
		u_net.write(network_event_mask_ofs, 8'hF4);
		u_net.write(network_event_mask_ofs + 16'h0001, 8'h0F);
		pending <= 8'hA5;
		fire(4'h1);
		fire(4'h2);
		repeat (3) @(posedge clk_sys_i);
		check("field", field, 16'h0A54);
		expect_rd(1'b0, network_event_request_ofs + 16'h0001, 8'h0A);
		chan_irq <= 16'h8001;
		expect_rd(1'b1, application_event_request_ofs + 16'h0001, 8'h01);
		expect_rd(1'b1, application_event_request_ofs + 16'h0002, 8'h80);
		expect_rd(1'b1, application_event_request_ofs + 16'h0003, 8'h00);
		// Odd ports disabled; three, two and one counting cycles
		errs <= '{enabled: 4'b0101, invalid_frame: 4'hF, receive_error: 4'hF,
			forwarded_error: 4'hF};
		@(posedge clk_sys_i);
		errs.forwarded_error <= 4'h0;
		@(posedge clk_sys_i);
		errs.receive_error <= 4'h0;
		@(posedge clk_sys_i);
		errs.invalid_frame <= 4'h0;
		for (int p = 0; p < 4; p++) begin
			expect_rd(1'b0, 16'h0300 + 16'(2 * p), p[0] ? 8'h00 : 8'h03);
			expect_rd(1'b0, 16'h0301 + 16'(2 * p), p[0] ? 8'h00 : 8'h02);
			expect_rd(1'b0, 16'h0308 + 16'(p), p[0] ? 8'h00 : 8'h01);
		end
		errs <= '{enabled: 4'hF, invalid_frame: 4'hF, receive_error: 4'hF,
			forwarded_error: 4'hF};
		repeat (260) @(posedge clk_sys_i);
		errs <= '{enabled: 4'hF, default: 4'h0};
		for (int a = 0; a < 12; a++) expect_rd(1'b0, 16'h0300 + 16'(a), 8'hFF);
		u_net.write(error_counters_last_ofs, 8'hAA);
		for (int a = 0; a < 12; a++) expect_rd(1'b0, 16'h0300 + 16'(a), 8'h00);
		// Mid-run reset: masks and sticky bits drop, mirrored channel bits stay live
		u_host.write(application_event_mask_ofs, 8'h40);
		repeat (2) @(posedge clk_sys_i);
		check("irq before reset", irq, 1'b1);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		check("irq after reset", irq, 1'b0);
		expect_rd(1'b1, application_event_mask_ofs, 8'h00);
		expect_rd(1'b0, network_event_request_ofs, 8'h50);
		expect_rd(1'b1, application_event_request_ofs, 8'h00);
		wrap_up();
	end
endmodule : testbench
